//--- hdl/rsq_pkg.sv
// package: constants and types for rx signal quality block
// How it works
// - strength code 1 dB steps, zero is -146 dBm
// - latch strength on sync, abort, rx timeout
// - live level register follows filter output
// - live level rereadable every byte, no increment
// - static mode: above threshold, release 3 dB below
// - dynamic modes need 6/12/18 dB rise or fall
// - carrier flag starts offset and timing recovery
// - preamble quality +1 on toggle, -4 on repeat
// - preamble valid when peak passes 4x threshold
// - sync quality is peak correlation with word
// - sync valid when peak passes length minus 2x threshold
// - sync threshold zero demands exact match
// - sync quality peak bits 5:0, bit 6 secondary
// - blanking suppresses data below threshold
// - toggle antennas in preamble until carrier, keep stronger
// - antenna select on pin and state bit 1
// - measure interval 24 * 2^filter_exp * 2^meas_time cycles
// - fsk: settle whole interval, sample at end
// - ook: settle interval, then peak interval
package rsq_pkg;
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_THRESH    = 8'h04;
  localparam logic [7:0] ADDR_ANT       = 8'h08;
  localparam logic [7:0] ADDR_SYNCW_A   = 8'h0c;
  localparam logic [7:0] ADDR_SYNCW_B   = 8'h10;
  localparam logic [7:0] ADDR_LIVE      = 8'h14;
  localparam logic [7:0] ADDR_LATCHED   = 8'h18;
  localparam logic [7:0] ADDR_PQ        = 8'h1c;
  localparam logic [7:0] ADDR_SQ        = 8'h20;
  localparam logic [7:0] ADDR_STATE     = 8'h24;
  localparam logic [7:0] ADDR_EVENTS    = 8'h28;
  // ctrl fields
  localparam int CTRL_CS_MODE_LSB   = 0;
  localparam int CTRL_SQ_EN_BIT     = 2;
  localparam int CTRL_PQ_TH_LSB     = 4;
  localparam int CTRL_SQ_TH_LSB     = 8;
  localparam int CTRL_SYNC_WORD_LENGTH_LSB  = 12;
  // antenna config fields
  localparam int ANT_EN_BIT         = 0;
  localparam int ANT_BLANK_BIT      = 1;
  localparam int ANT_OOK_BIT        = 2;
  localparam int ANT_MEAS_LSB       = 4;
  localparam int ANT_FLT_E_LSB      = 8;
  localparam int STATE_ANT_BIT      = 1;
  localparam int STATE_CS_BIT       = 0;
  localparam logic [7:0] CS_HYST_DB    = 8'h03;
  localparam logic [7:0] CS_STEP_DB    = 8'h06;
  localparam logic [7:0] PQ_INC        = 8'h01;
  localparam logic [7:0] PQ_DEC        = 8'h04;
  localparam logic [5:0] SYNC_WORD_LENGTH_RST  = 6'h20;
  localparam logic [4:0] MEAS_BASE     = 5'h18;
  localparam logic [1:0] CS_STATIC     = 2'h0;
  typedef enum logic [3:0] {
    RSQ_AS_IDLE   = 4'h1,
    RSQ_AS_SETTLE = 4'h2,
    RSQ_AS_PEAK   = 4'h4,
    RSQ_AS_HOLD   = 4'h8
  } rsq_as_state_t;
endpackage

//--- hdl/rsq_pq_if.sv
// interface: bit stream and quality results between modules
`timescale 1ns/1ps
interface rsq_pq_if;
  logic       bit_valid;
  logic       bit_val;
  logic       restart;
  logic [7:0] quality;
  logic [7:0] peak;
  modport src (output bit_valid, output bit_val, output restart, input quality, input peak);
  modport cnt (input bit_valid, input bit_val, input restart, output quality, output peak);
endinterface

//--- hdl/rsq_preamble.sv
// preamble quality counter with running peak
`timescale 1ns/1ps
module rsq_preamble (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // bit stream
  rsq_pq_if.cnt     pq
);
  typedef struct packed {
    logic [7:0] q;
    logic [7:0] pk;
    logic       last;
    logic       have;
  } rsq_pq_st_t;
  rsq_pq_st_t s_q, s_d;
  always_comb
  begin
    s_d = s_q;
    if (pq.restart)
    begin
      s_d = '0;
    end
    else if (pq.bit_valid)
    begin
      s_d.have = 1'b1;
      s_d.last = pq.bit_val;
      if (s_q.have && (pq.bit_val != s_q.last))
      begin
        if (s_q.q != 8'hff)
          s_d.q = s_q.q + rsq_pkg::PQ_INC;
      end
      else if (s_q.have)
      begin
        s_d.q = (s_q.q > rsq_pkg::PQ_DEC) ? s_q.q - rsq_pkg::PQ_DEC : 8'h00;
      end
      if (s_d.q > s_q.pk)
        s_d.pk = s_d.q;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '0;
    else if (clk_en)
      s_q <= s_d;
  end
  assign pq.quality = s_q.q;
  assign pq.peak    = s_q.pk;
endmodule // rsq_preamble

//--- hdl/rsq_meas_timer.sv
// antenna measurement interval timer
`timescale 1ns/1ps
module rsq_meas_timer #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  // control
  input  wire logic             start,
  input  wire logic [3:0]       flt_exp,
  input  wire logic [3:0]       meas_exp,
  output logic                  done
);
  initial
  begin
    if (CNT_W < 28)
      $error("rsq_meas_timer: counter too narrow");
  end
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             run;
    logic             dn;
  } rsq_tm_st_t;
  rsq_tm_st_t s_q, s_d;
  logic [CNT_W-1:0] limit;
  always_comb
  begin
    limit = (CNT_W'(rsq_pkg::MEAS_BASE) << flt_exp) << meas_exp;
    s_d    = s_q;
    s_d.dn = 1'b0;
    if (start)
    begin
      s_d.cnt = CNT_W'(1);
      s_d.run = 1'b1;
    end
    else if (s_q.run)
    begin
      if (s_q.cnt >= limit)
      begin
        s_d.run = 1'b0;
        s_d.dn  = 1'b1;
      end
      else
        s_d.cnt = s_q.cnt + CNT_W'(1);
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '0;
    else if (clk_en)
      s_q <= s_d;
  end
  assign done = s_q.dn;
endmodule // rsq_meas_timer

//--- hdl/rsq_top.sv
// receive signal quality and antenna diversity top
`timescale 1ns/1ps
module rsq_top #(
  parameter int SYNC_W = 32
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // receiver side
  input  wire logic [7:0]  strength_in,
  input  wire logic        rx_active,
  input  wire logic        sync_done,
  input  wire logic        abort_command,
  input  wire logic        rx_timeout,
  input  wire logic        demod_data,
  input  wire logic        demod_clk,
  // outputs
  output logic             rx_data_out,
  output logic             carrier_sense,
  output logic             recovery_start,
  output logic             preamble_valid,
  output logic             sync_valid,
  output logic             antenna_select_pin
);
  initial
  begin
    if (SYNC_W != 32)
      $error("rsq_top: sync word width must be 32");
  end
  typedef struct packed {
    logic [1:0]    clk_sy;
    logic [1:0]    dat_sy;
    logic          clk_prev;
    logic [1:0]    cs_mode;
    logic          sq_en;
    logic [3:0]    pq_th;
    logic [2:0]    sq_th;
    logic [5:0]    sync_word_length;
    logic [7:0]    thresh;
    logic          ant_en;
    logic          blank_en;
    logic          ook;
    logic [3:0]    meas_t;
    logic [3:0]    flt_e;
    logic [31:0]   syncw_a;
    logic [31:0]   syncw_b;
    logic [7:0]    live;
    logic [7:0]    latched;
    logic [7:0]    ref_lvl;
    logic          cs;
    logic          rec;
    logic [31:0]   shreg;
    logic [5:0]    sq_pk;
    logic          sq_sec;
    logic          pv;
    logic          sv;
    logic          ant;
    logic [7:0]    ant_meas;
    logic [7:0]    ant_peak;
    rsq_pkg::rsq_as_state_t as_st;
    logic          rx_prev;
    logic          data_o;
    logic [31:0]   rdata;
  } rsq_st_t;
  rsq_st_t s_q, s_d;
  rsq_pq_if pq ();
  logic tm_start;
  logic tm_done;
  rsq_preamble u_pre (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .pq      (pq.cnt)
  );
  rsq_meas_timer #(.CNT_W(32)) u_tm (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .start    (tm_start),
    .flt_exp  (s_q.flt_e),
    .meas_exp (s_q.meas_t),
    .done     (tm_done)
  );
  logic       bit_strobe;
  logic [5:0] match_a;
  logic [5:0] match_b;
  logic [31:0] nxt_sh;
  logic [5:0] sq_limit;
  logic [7:0] step_db;
  logic [7:0] pq_limit;
  always_comb
  begin
    bit_strobe = s_q.clk_sy[1] && !s_q.clk_prev;
    nxt_sh     = {s_q.shreg[30:0], s_q.dat_sy[1]};
    match_a    = '0;
    match_b    = '0;
    for (int i = 0; i < SYNC_W; i++)
    begin
      if (i < int'(s_q.sync_word_length))
      begin
        match_a = match_a + 6'((nxt_sh[i] == s_q.syncw_a[i]) ? 1 : 0);
        match_b = match_b + 6'((nxt_sh[i] == s_q.syncw_b[i]) ? 1 : 0);
      end
    end
    sq_limit = s_q.sync_word_length - {2'h0, s_q.sq_th, 1'b0};
    step_db  = 8'(rsq_pkg::CS_STEP_DB * s_q.cs_mode);
    pq_limit = {2'h0, s_q.pq_th, 2'h0};
  end
  assign pq.bit_valid = bit_strobe && s_q.rx_prev;
  assign pq.bit_val   = s_q.dat_sy[1];
  assign pq.restart   = rx_active && !s_q.rx_prev;
  always_comb
  begin
    s_d          = s_q;
    tm_start     = 1'b0;
    s_d.clk_sy   = {s_q.clk_sy[0], demod_clk};
    s_d.dat_sy   = {s_q.dat_sy[0], demod_data};
    s_d.clk_prev = s_q.clk_sy[1];
    s_d.rx_prev  = rx_active;
    s_d.live     = strength_in;
    if (sync_done || abort_command || rx_timeout)
      s_d.latched = strength_in;
    if (s_q.cs_mode == rsq_pkg::CS_STATIC)
    begin
      if (strength_in > s_q.thresh)
        s_d.cs = 1'b1;
      else if (s_q.thresh >= rsq_pkg::CS_HYST_DB && strength_in <= s_q.thresh - rsq_pkg::CS_HYST_DB)
        s_d.cs = 1'b0;
    end
    else
    begin
      if (!s_q.cs)
      begin
        if (strength_in < s_q.ref_lvl)
          s_d.ref_lvl = strength_in;
        if (strength_in > s_q.thresh && {1'b0, strength_in} >= {1'b0, s_q.ref_lvl} + {1'b0, step_db})
        begin
          s_d.cs      = 1'b1;
          s_d.ref_lvl = strength_in;
        end
      end
      else
      begin
        if (strength_in > s_q.ref_lvl)
          s_d.ref_lvl = strength_in;
        if ({1'b0, strength_in} + {1'b0, step_db} <= {1'b0, s_q.ref_lvl})
        begin
          s_d.cs      = 1'b0;
          s_d.ref_lvl = strength_in;
        end
      end
    end
    // registered pulse on carrier rise
    s_d.rec    = s_d.cs && !s_q.cs;
    s_d.data_o = (s_q.blank_en && strength_in < s_q.thresh) ? 1'b0 : s_q.dat_sy[1];
    if (pq.restart)
    begin
      s_d.pv     = 1'b0;
      s_d.sv     = 1'b0;
      s_d.sq_pk  = '0;
      s_d.sq_sec = 1'b0;
      s_d.shreg  = '0;
    end
    else if (pq.bit_valid)
    begin
      s_d.shreg = nxt_sh;
      if (match_a > s_q.sq_pk)
      begin
        s_d.sq_pk  = match_a;
        s_d.sq_sec = 1'b0;
      end
      if (match_b > s_q.sq_pk && match_b > match_a)
      begin
        s_d.sq_pk  = match_b;
        s_d.sq_sec = 1'b1;
      end
    end
    if (pq.peak >= pq_limit && s_q.rx_prev)
      s_d.pv = 1'b1;
    if (!pq.restart && s_q.sq_en && s_q.sq_pk >= sq_limit && s_q.sq_pk != '0)
      s_d.sv = 1'b1;
    unique case (s_q.as_st)
      rsq_pkg::RSQ_AS_IDLE:
      begin
        if (s_q.ant_en && rx_active)
        begin
          s_d.as_st = rsq_pkg::RSQ_AS_SETTLE;
          tm_start  = 1'b1;
        end
      end
      rsq_pkg::RSQ_AS_SETTLE:
      begin
        if (tm_done)
        begin
          if (s_q.ook)
          begin
            s_d.as_st    = rsq_pkg::RSQ_AS_PEAK;
            s_d.ant_peak = '0;
            tm_start     = 1'b1;
          end
          else
          begin
            s_d.ant_meas = strength_in;
            if (s_q.cs)
            begin
              s_d.as_st = rsq_pkg::RSQ_AS_HOLD;
              if (s_q.ant_meas > strength_in)
                s_d.ant = !s_q.ant;
            end
            else
            begin
              s_d.ant  = !s_q.ant;
              tm_start = 1'b1;
            end
          end
        end
      end
      rsq_pkg::RSQ_AS_PEAK:
      begin
        if (strength_in > s_q.ant_peak)
          s_d.ant_peak = strength_in;
        if (tm_done)
        begin
          s_d.ant_meas = s_q.ant_peak;
          if (s_q.cs)
          begin
            s_d.as_st = rsq_pkg::RSQ_AS_HOLD;
            if (s_q.ant_meas > s_q.ant_peak)
              s_d.ant = !s_q.ant;
          end
          else
          begin
            s_d.as_st = rsq_pkg::RSQ_AS_SETTLE;
            s_d.ant   = !s_q.ant;
            tm_start  = 1'b1;
          end
        end
      end
      rsq_pkg::RSQ_AS_HOLD:
      begin
        if (!rx_active || !s_q.ant_en)
          s_d.as_st = rsq_pkg::RSQ_AS_IDLE;
      end
      default:
        s_d.as_st = rsq_pkg::RSQ_AS_IDLE;
    endcase
    if (!rx_active && s_q.as_st != rsq_pkg::RSQ_AS_HOLD)
      s_d.as_st = rsq_pkg::RSQ_AS_IDLE;
    if (reg_wr)
    begin
      unique case (reg_addr)
        rsq_pkg::ADDR_CTRL:
        begin
          s_d.cs_mode  = reg_wdata[rsq_pkg::CTRL_CS_MODE_LSB +: 2];
          s_d.sq_en    = reg_wdata[rsq_pkg::CTRL_SQ_EN_BIT];
          s_d.pq_th    = reg_wdata[rsq_pkg::CTRL_PQ_TH_LSB +: 4];
          s_d.sq_th    = reg_wdata[rsq_pkg::CTRL_SQ_TH_LSB +: 3];
          s_d.sync_word_length = reg_wdata[rsq_pkg::CTRL_SYNC_WORD_LENGTH_LSB +: 6];
        end
        rsq_pkg::ADDR_THRESH: s_d.thresh  = reg_wdata[7:0];
        rsq_pkg::ADDR_ANT:
        begin
          s_d.ant_en   = reg_wdata[rsq_pkg::ANT_EN_BIT];
          s_d.blank_en = reg_wdata[rsq_pkg::ANT_BLANK_BIT];
          s_d.ook      = reg_wdata[rsq_pkg::ANT_OOK_BIT];
          s_d.meas_t   = reg_wdata[rsq_pkg::ANT_MEAS_LSB +: 4];
          s_d.flt_e    = reg_wdata[rsq_pkg::ANT_FLT_E_LSB +: 4];
        end
        rsq_pkg::ADDR_SYNCW_A: s_d.syncw_a = reg_wdata;
        rsq_pkg::ADDR_SYNCW_B: s_d.syncw_b = reg_wdata;
        default: ;
      endcase
    end
    s_d.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        rsq_pkg::ADDR_CTRL:    s_d.rdata = 32'({s_q.sync_word_length, 1'b0, s_q.sq_th, s_q.pq_th, 1'b0, s_q.sq_en,
                                                 s_q.cs_mode});
        rsq_pkg::ADDR_THRESH:  s_d.rdata = 32'(s_q.thresh);
        rsq_pkg::ADDR_ANT:     s_d.rdata = 32'({s_q.flt_e, s_q.meas_t, 1'b0, s_q.ook, s_q.blank_en, s_q.ant_en});
        rsq_pkg::ADDR_SYNCW_A: s_d.rdata = s_q.syncw_a;
        rsq_pkg::ADDR_SYNCW_B: s_d.rdata = s_q.syncw_b;
        rsq_pkg::ADDR_LIVE:    s_d.rdata = 32'(s_q.live);
        rsq_pkg::ADDR_LATCHED: s_d.rdata = 32'(s_q.latched);
        rsq_pkg::ADDR_PQ:      s_d.rdata = 32'(pq.peak);
        rsq_pkg::ADDR_SQ:      s_d.rdata = 32'({s_q.sq_sec, s_q.sq_pk});
        rsq_pkg::ADDR_STATE:   s_d.rdata = 32'({s_q.ant, s_q.cs});
        rsq_pkg::ADDR_EVENTS:  s_d.rdata = 32'({s_q.sv, s_q.pv});
        default:               s_d.rdata = '0;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q          <= '0;
      s_q.as_st    <= rsq_pkg::RSQ_AS_IDLE;
      s_q.sync_word_length <= rsq_pkg::SYNC_WORD_LENGTH_RST;
      s_q.sq_en    <= 1'b1;
      s_q.ref_lvl  <= 8'hff;
    end
    else if (clk_en)
      s_q <= s_d;
  end
  assign reg_rdata          = s_q.rdata;
  assign rx_data_out        = s_q.data_o;
  assign carrier_sense      = s_q.cs;
  assign recovery_start     = s_q.rec;
  assign preamble_valid     = s_q.pv;
  assign sync_valid         = s_q.sv;
  assign antenna_select_pin = s_q.ant;
endmodule // rsq_top

//--- verification/rsq_top_asserts.sv
// checker: port-level properties of rsq_top
`timescale 1ns/1ps
module rsq_top_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // receiver side
  input wire logic [7:0]  strength_in,
  input wire logic        rx_active,
  // outputs
  input wire logic        rx_data_out,
  input wire logic        carrier_sense,
  input wire logic        recovery_start,
  input wire logic        preamble_valid,
  input wire logic        sync_valid,
  input wire logic        antenna_select_pin
);
  logic [7:0]  th_q;
  logic [17:0] ctl_q;
  logic [1:0]  ant_q;
  wire         st = (ctl_q[1:0] == rsq_pkg::CS_STATIC);
  // shadow copies of threshold, control and antenna fields
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      th_q  <= 8'h00;
      ctl_q <= 18'h20004;
      ant_q <= 2'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == rsq_pkg::ADDR_THRESH) th_q <= reg_wdata[7:0];
      if (reg_addr == rsq_pkg::ADDR_CTRL) ctl_q <= reg_wdata[17:0];
      if (reg_addr == rsq_pkg::ADDR_ANT) ant_q <= reg_wdata[1:0];
    end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_rd_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_cs_rise: assert property ($rose(carrier_sense) && st |->
    $past(strength_in) > th_q || $past(strength_in, 2) > th_q)
    else $error("carrier set without strength above threshold");
  a_cs_fall: assert property ($fell(carrier_sense) && st |->
    {1'b0, $past(strength_in)} + 9'h3 <= {1'b0, th_q} || {1'b0, $past(strength_in, 2)} + 9'h3 <= {1'b0, th_q})
    else $error("carrier cleared above release level");
  a_rec_follows: assert property ($rose(carrier_sense) |-> ##[0:2] recovery_start)
    else $error("no recovery start on carrier rise");
  a_rec_single: assert property (recovery_start |=> !recovery_start)
    else $error("recovery start longer than one cycle");
  a_pv_in_rx: assert property ($rose(preamble_valid) |-> rx_active || $past(rx_active))
    else $error("preamble valid outside receive");
  a_pv_sticky: assert property (preamble_valid && rx_active && $past(rx_active) && $past(rx_active, 2)
    |=> preamble_valid)
    else $error("preamble valid dropped within receive");
  a_sv_enabled: assert property ($rose(sync_valid) |-> ctl_q[2] || $past(ctl_q[2]))
    else $error("sync valid with checking disabled");
  a_blank_low: assert property ((ant_q[1] && strength_in < th_q) [*3] |=> !rx_data_out)
    else $error("data passed while blanked");
  a_ant_enabled: assert property ($changed(antenna_select_pin) |-> $past(ant_q[0]))
    else $error("antenna switched while disabled");
  c_cs_rise: cover property ($rose(carrier_sense));
  c_sv_rise: cover property ($rose(sync_valid));
  c_ant_move: cover property ($changed(antenna_select_pin));
endmodule // rsq_top_asserts

bind rsq_top rsq_top_asserts rsq_top_asserts_i (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .strength_in, .rx_active, .rx_data_out, .carrier_sense, .recovery_start, .preamble_valid,
  .sync_valid, .antenna_select_pin);

//--- verification/rsq_demod_model.sv
// far-end demodulator model: bit stream with its link clock
`timescale 1ns/1ps
module rsq_demod_model (
  // request
  input  wire logic        send,
  input  wire logic [31:0] bits,
  input  wire logic [5:0]  nbits,
  // link pins
  output logic             demod_clk,
  output logic             demod_data,
  output logic             busy
);
  initial
  begin
    demod_clk  = 1'b0;
    demod_data = 1'b0;
    busy       = 1'b0;
  end
  // msb first, clock runs only within a frame
  always @(posedge send)
  begin
    busy = 1'b1;
    #3.7;
    for (int i = int'(nbits) - 1; i >= 0; i--)
    begin
      demod_data = bits[i];
      #62.5 demod_clk = 1'b1;
      #62.5 demod_clk = 1'b0;
    end
    demod_data = ~demod_data;
    busy = 1'b0;
  end
endmodule // rsq_demod_model

//--- verification/testbench.sv
// testbench: register-level scenarios for rsq_top
`timescale 1ns/1ps
module testbench;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  strength_in = 8'h00;
  logic        rx_active = 1'b0;
  logic        sync_done = 1'b0;
  logic        abort_command = 1'b0;
  logic        rx_timeout = 1'b0;
  logic        demod_data, demod_clk, busy, send = 1'b0, ant_on = 1'b0;
  logic        rx_data_out, carrier_sense, recovery_start, preamble_valid, sync_valid, antenna_select_pin;
  logic [31:0] bits = 32'h0;
  logic [5:0]  nbits = 6'h0;
  logic [7:0]  sv [4] = '{8'h50, 8'h51, 8'h4e, 8'h4d};
  logic [31:0] sw [4] = '{32'h3a5c96e1, 32'h3a5c96e0, 32'h3a5c96e0, 32'hc5a3691e};
  logic [7:0]  sq [4] = '{8'h20, 8'h1f, 8'h1f, 8'h60};
  int          error_cnt = 0;
  int          checks = 0;
  int          ones = 0;
  int          gap;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rx_data_out === 1'b1) ones++;
  always @(posedge ref_clk) if (ant_on) strength_in <= antenna_select_pin ? 8'h60 : 8'h30;
  rsq_top rsq_top_i (.ref_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .strength_in, .rx_active, .sync_done, .abort_command, .rx_timeout, .demod_data, .demod_clk,
    .rx_data_out, .carrier_sense, .recovery_start, .preamble_valid, .sync_valid, .antenna_select_pin);
  rsq_demod_model rsq_demod_model_i (.send, .bits, .nbits, .demod_clk, .demod_data, .busy);
  task automatic summarize;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, e);
  endtask
  task automatic frame(input logic [31:0] b, input logic [5:0] len);
    int c;
    @(posedge ref_clk);
    bits <= b;
    nbits <= len;
    send <= 1'b1;
    @(posedge ref_clk);
    send <= 1'b0;
    for (c = 0; busy !== 1'b0 && c < 2000; c++) @(posedge ref_clk);
    if (c >= 2000) begin error_cnt++; summarize(); end
    wt(8);
  endtask
  task automatic wchg(output int c);
    logic p;
    p = antenna_select_pin;
    for (c = 0; antenna_select_pin === p && c < 300; c++) @(posedge ref_clk);
    if (c >= 300) begin error_cnt++; summarize(); end
  endtask
  initial
  begin
    wt(5);
    reset_n <= 1'b1;
    rdc(rsq_pkg::ADDR_CTRL, 32'h0002_0004);
    rdc(8'h3c, 32'h0);
    rdc(rsq_pkg::ADDR_THRESH, 32'h0);
    strength_in <= 8'h5a;
    wt(3);
    // back-to-back live reads, address held
    @(posedge ref_clk);
    reg_addr <= rsq_pkg::ADDR_LIVE;
    reg_rd <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk);
      if (k == 1) reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, 32'h5a);
    end
    // capture on each of the three causes
    for (int k = 0; k < 3; k++)
    begin
      strength_in <= 8'h40 + 8'(k);
      wt(3);
      sync_done <= (k == 0);
      abort_command <= (k == 1);
      rx_timeout <= (k == 2);
      wt(1);
      {sync_done, abort_command, rx_timeout} <= 3'b000;
      strength_in <= 8'h11;
      wt(3);
      rdc(rsq_pkg::ADDR_LATCHED, 32'h40 + 32'(k));
      rdc(rsq_pkg::ADDR_LIVE, 32'h11);
    end
    // static carrier sense with 3 dB release
    wr(rsq_pkg::ADDR_THRESH, 32'h50);
    wt(1);
    for (int k = 0; k < 4; k++)
    begin
      strength_in <= sv[k];
      wt(4);
      rdc(rsq_pkg::ADDR_STATE, 32'(4'b0110 >> k) & 32'h1);
    end
    // dynamic modes: rise, small fall, full fall
    strength_in <= 8'h08;
    wr(rsq_pkg::ADDR_THRESH, 32'h20);
    for (int m = 1; m < 4; m++)
    begin
      strength_in <= 8'h08;
      wr(rsq_pkg::ADDR_CTRL, 32'h20004 | 32'(m));
      wt(4);
      strength_in <= 8'h60;
      wt(4);
      chk(32'(carrier_sense), 32'h1);
      strength_in <= 8'h61 - 8'(6 * m);
      wt(4);
      chk(32'(carrier_sense), 32'h1);
      strength_in <= 8'h5f - 8'(6 * m);
      wt(4);
      chk(32'(carrier_sense), 32'h0);
    end
    // preamble: floor at zero, cleared per attempt, threshold 16 then 12
    for (int t = 4; t > 2; t--)
    begin
      rx_active <= 1'b0;
      wr(rsq_pkg::ADDR_CTRL, 32'h20004 | 32'(t << 4));
      rx_active <= 1'b1;
      wt(2);
      frame(32'h1555, 6'd17);
      rdc(rsq_pkg::ADDR_PQ, 32'hd);
      chk(32'(preamble_valid), 32'(t == 3));
    end
    // sync words: exact, one error, relaxed threshold, secondary
    wr(rsq_pkg::ADDR_SYNCW_A, 32'h3a5c96e1);
    wr(rsq_pkg::ADDR_SYNCW_B, 32'hc5a3691e);
    for (int r = 0; r < 4; r++)
    begin
      rx_active <= 1'b0;
      wr(rsq_pkg::ADDR_CTRL, 32'h20004 | (32'(r == 2) << 8));
      rx_active <= 1'b1;
      wt(2);
      frame(sw[r], 6'd32);
      rdc(rsq_pkg::ADDR_SQ, 32'(sq[r]));
      chk(32'(sync_valid), 32'(r != 1));
    end
    // blanking below and above threshold
    wr(rsq_pkg::ADDR_THRESH, 32'h50);
    wr(rsq_pkg::ADDR_ANT, 32'h2);
    for (int k = 0; k < 2; k++)
    begin
      strength_in <= k ? 8'h60 : 8'h10;
      wt(4);
      ones = 0;
      frame(32'hffffffff, 6'd32);
      chk(32'(ones > 0), 32'(k));
    end
    // antenna switching, fsk then ook, stronger antenna is 1
    for (int o = 0; o < 2; o++)
    begin
      ant_on <= 1'b0;
      rx_active <= 1'b0;
      strength_in <= 8'h30;
      wr(rsq_pkg::ADDR_ANT, 32'h1 | 32'(o << 2));
      rx_active <= 1'b1;
      wchg(gap);
      wchg(gap);
      chk(32'(gap >= 24 * (o + 1) && gap <= 26 * (o + 1)), 32'h1);
      ant_on <= 1'b1;
      wt(160);
      chk(32'(antenna_select_pin), 32'h1);
      wt(60);
      rdc(rsq_pkg::ADDR_STATE, 32'h3);
    end
    summarize();
  end
endmodule // testbench
